/* shared/cpm_map.vh */
`ifndef CPM_MAP_VH
`define CPM_MAP_VH
// ****************************************
// register offsets (byte addresses are 4x)
// ****************************************
`define CPM_OFS_POWER_CONTROL      8'h87
`define CPM_OFS_MEMORY_WAIT_CONFIG 8'h8E
`define CPM_OFS_PORT1_WAKE_ENABLE  8'h91
`define CPM_OFS_CPU_DIVIDER_SELECT 8'hE5
`define CPM_OFS_CLOCK_APPLY_CMD    8'hE6
`define CPM_OFS_WAKE_CONTROL       8'hF0
// ****************************************
// field positions
// ****************************************
`define CPM_PC_IDLE_BIT      0
`define CPM_PC_STOP_BIT      1
`define CPM_PC_FLAG_BIT      2
`define CPM_PC_UPSEL_BIT     3
`define CPM_MW_XRD_LSB       0
`define CPM_MW_XWR_BIT       3
`define CPM_MW_PRD_LSB       4
`define CPM_WC_RC_OSC_BIT    0
// ****************************************
// reset values and codes
// ****************************************
`define CPM_RST_PROG_WAIT    3'h7
`define CPM_RST_XRAM_WAIT    3'h1
`define CPM_RST_DIVIDER      3'h7
`define CPM_RST_UPSEL        1'h1
`define CPM_APPLY_CODE       8'h69
`define CPM_XWR_EXTRA        3'h1
// ****************************************
// settling interval, in oscillator enables
// ****************************************
`define CPM_SETTLE_XTAL      12'h800
`define CPM_SETTLE_RC        12'h040
`define CPM_SETTLE_LOW       3'h5
`endif

/* verilog/cpm_wait_gen.v */
`timescale 1ns/10ps
`include "cpm_map.vh"
// ****************************************
// memory access stretcher
// ****************************************
module cpm_wait_gen (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // access request from core
  input  wire       start_i,
  input  wire [2:0] extra_i,
  // wait back to core
  output reg        wait_o
);
  reg [2:0] cnt_r;

  // wait asserts for exactly extra_i cycles after start
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 3'h0;
      wait_o <= 1'b0;
    end else if (start_i && (cnt_r == 3'h0)) begin
      cnt_r  <= extra_i;
      wait_o <= (extra_i != 3'h0);
    end else if (cnt_r != 3'h0) begin
      cnt_r  <= cnt_r - 3'h1;
      wait_o <= (cnt_r != 3'h1);
    end else begin
      wait_o <= 1'b0;
    end
  end
endmodule // cpm_wait_gen

/* verilog/cpm_ctrl.v */
`timescale 1ns/10ps
`include "cpm_map.vh"
// Operation
// - program reads stretched by 0..7 cycles, reset 7
// - xram reads stretched by 0..7, reset 1
// - write extension bit adds one xram write cycle
// - cpu divider 128 down to 1, reset /1
// - code 0x69 applies pending divider selection
// - upper address from port2 latch or zero
// - stop bit halts cpu, peripherals, oscillator
// - idle bit gates only cpu clock
// - port1 pin wakes only when enabled
// - wake clears mode bit in hardware
// - stop wakes on pins; idle also interrupts
// - stop wake waits oscillator settling interval
module cpm_ctrl (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // oscillator side
  input  wire        osc_tick_i,
  input  wire        lowosc_tick_i,
  // memory access timing
  input  wire        prog_rd_i,
  input  wire        xram_rd_i,
  input  wire        xram_wr_i,
  input  wire        xram_indirect_i,
  input  wire [7:0]  port2_output_latch_i,
  output reg         prog_wait_o,
  output reg         xram_wait_o,
  output reg  [7:0]  xram_upper_addr_o,
  // ports and interrupt wake sources
  input  wire [7:0]  port0_pins_i,
  input  wire [7:0]  port1_pins_i,
  input  wire        irq_pending_i,
  input  wire        global_irq_en_i,
  // clock and power outputs
  output reg         cpu_clk_en_o,
  output reg         cpu_halt_o,
  output reg         periph_halt_o,
  output reg         osc_stop_o,
  output reg  [2:0]  cpu_divider_code_o
);
  // ****************************************
  // state encodings
  // ****************************************
  localparam [3:0] ST_RUN    = 4'h1;
  localparam [3:0] ST_IDLE   = 4'h2;
  localparam [3:0] ST_STOP   = 4'h4;
  localparam [3:0] ST_SETTLE = 4'h8;

  // ****************************************
  // registers
  // ****************************************
  reg [2:0]  program_read_wait_r;
  reg [2:0]  xram_read_wait_r;
  reg        xram_write_extend_r;
  reg [2:0]  cpu_divider_sel_r;
  reg [2:0]  active_div_r;
  reg        upper_address_select_r;
  reg        general_flag_r;
  reg        idle_r;
  reg        stop_r;
  reg [7:0]  port1_wake_enable_r;
  reg        rc_osc_r;
  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [7:0]  p0_last_r;
  reg [7:0]  p1_last_r;
  reg [11:0] settle_hi_r;
  reg [2:0]  settle_lo_r;
  reg [6:0]  div_cnt_r;
  wire       prog_wait_w;
  wire       xrd_wait_w;

  // word index decode, used by read and write paths
  function is_reg;
    input [9:0] a;
    input [7:0] ofs;
    begin
      is_reg = (a[9:2] == ofs);
    end
  endfunction

  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire wr_lo  = wb_req & we_i & sel_i[0];

  // ****************************************
  // bus answer: one-cycle ack, any address
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h0;
      if (wb_req && !we_i) begin
        if (is_reg(adr_i[9:0], `CPM_OFS_MEMORY_WAIT_CONFIG))
          dat_o[7:0] <= {1'b0, program_read_wait_r, xram_write_extend_r, xram_read_wait_r};
        else if (is_reg(adr_i[9:0], `CPM_OFS_CPU_DIVIDER_SELECT))
          dat_o[7:0] <= {5'h0, cpu_divider_sel_r};
        else if (is_reg(adr_i[9:0], `CPM_OFS_POWER_CONTROL))
          dat_o[7:0] <= {4'h0, upper_address_select_r, general_flag_r, stop_r, idle_r};
        else if (is_reg(adr_i[9:0], `CPM_OFS_PORT1_WAKE_ENABLE))
          dat_o[7:0] <= port1_wake_enable_r;
        else if (is_reg(adr_i[9:0], `CPM_OFS_WAKE_CONTROL))
          dat_o[7:0] <= {7'h0, rc_osc_r};
        // command register and unmapped words read zero
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      program_read_wait_r    <= `CPM_RST_PROG_WAIT;
      xram_read_wait_r       <= `CPM_RST_XRAM_WAIT;
      xram_write_extend_r    <= 1'b0;
      cpu_divider_sel_r      <= `CPM_RST_DIVIDER;
      active_div_r           <= `CPM_RST_DIVIDER;
      upper_address_select_r <= `CPM_RST_UPSEL;
      general_flag_r         <= 1'b0;
      port1_wake_enable_r    <= 8'h00;
      rc_osc_r               <= 1'b0;
    end else if (wr_lo) begin
      if (is_reg(adr_i, `CPM_OFS_MEMORY_WAIT_CONFIG)) begin
        program_read_wait_r <= dat_i[`CPM_MW_PRD_LSB+2:`CPM_MW_PRD_LSB];
        xram_write_extend_r <= dat_i[`CPM_MW_XWR_BIT];
        xram_read_wait_r    <= dat_i[`CPM_MW_XRD_LSB+2:`CPM_MW_XRD_LSB];
      end
      if (is_reg(adr_i, `CPM_OFS_CPU_DIVIDER_SELECT))
        cpu_divider_sel_r <= dat_i[2:0];
      // only the apply code moves the pending selection
      if (is_reg(adr_i, `CPM_OFS_CLOCK_APPLY_CMD) && dat_i[7:0] == `CPM_APPLY_CODE)
        active_div_r <= cpu_divider_sel_r;
      if (is_reg(adr_i, `CPM_OFS_POWER_CONTROL)) begin
        upper_address_select_r <= dat_i[`CPM_PC_UPSEL_BIT];
        general_flag_r         <= dat_i[`CPM_PC_FLAG_BIT];
      end
      if (is_reg(adr_i, `CPM_OFS_PORT1_WAKE_ENABLE))
        port1_wake_enable_r <= dat_i[7:0];
      if (is_reg(adr_i, `CPM_OFS_WAKE_CONTROL))
        rc_osc_r <= dat_i[`CPM_WC_RC_OSC_BIT];
    end
  end

  // ****************************************
  // wake detection
  // ****************************************
  // level change on port 0 always, port 1 only where enabled
  wire pin_wake = (|(port0_pins_i ^ p0_last_r)) |
                  (|((port1_pins_i ^ p1_last_r) & port1_wake_enable_r));
  wire irq_wake = irq_pending_i & global_irq_en_i;
  wire pc_wr    = wr_lo & is_reg(adr_i, `CPM_OFS_POWER_CONTROL);
  wire settled  = (settle_hi_r == 12'h0) && (settle_lo_r == 3'h0);

  always @(posedge clk_i) begin
    if (rst_i) begin
      p0_last_r <= 8'h00;
      p1_last_r <= 8'h00;
    end else begin
      p0_last_r <= port0_pins_i;
      p1_last_r <= port1_pins_i;
    end
  end

  // ****************************************
  // power mode machine
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // stop outranks idle if both written together
        if (pc_wr && dat_i[`CPM_PC_STOP_BIT])
          state_nxt = ST_STOP;
        else if (pc_wr && dat_i[`CPM_PC_IDLE_BIT])
          state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (pin_wake || irq_wake)
          state_nxt = ST_RUN;
      end
      ST_STOP: begin
        if (pin_wake)
          state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settled)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ST_RUN;
      idle_r      <= 1'b0;
      stop_r      <= 1'b0;
      settle_hi_r <= 12'h0;
      settle_lo_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      idle_r  <= (state_nxt == ST_IDLE);
      stop_r  <= (state_nxt == ST_STOP) || (state_nxt == ST_SETTLE);
      // settling: high-speed count then low-speed count
      if (state_r == ST_STOP && state_nxt == ST_SETTLE) begin
        settle_hi_r <= rc_osc_r ? `CPM_SETTLE_RC : `CPM_SETTLE_XTAL;
        settle_lo_r <= `CPM_SETTLE_LOW;
      end else if (state_r == ST_SETTLE) begin
        if (settle_hi_r != 12'h0) begin
          if (osc_tick_i)
            settle_hi_r <= settle_hi_r - 12'h1;
        end else if (settle_lo_r != 3'h0 && lowosc_tick_i) begin
          settle_lo_r <= settle_lo_r - 3'h1;
        end
      end
    end
  end

  // ****************************************
  // cpu clock divider and gating
  // ****************************************
  // terminal count 2^(7-code)-1: code 0 -> /128, code 7 -> /1
  wire [6:0] div_term = (7'h7F >> active_div_r);
  wire       div_hit  = (div_cnt_r == div_term);

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r          <= 7'h0;
      cpu_clk_en_o       <= 1'b0;
      cpu_halt_o         <= 1'b0;
      periph_halt_o      <= 1'b0;
      osc_stop_o         <= 1'b0;
      cpu_divider_code_o <= `CPM_RST_DIVIDER;
    end else begin
      // counter frozen in stop since the oscillator is off
      if (state_r != ST_STOP)
        div_cnt_r <= div_hit ? 7'h0 : div_cnt_r + 7'h1;
      cpu_clk_en_o       <= div_hit && (state_nxt == ST_RUN);
      cpu_halt_o         <= (state_nxt != ST_RUN);
      periph_halt_o      <= (state_nxt == ST_STOP) || (state_nxt == ST_SETTLE);
      osc_stop_o         <= (state_nxt == ST_STOP);
      cpu_divider_code_o <= active_div_r;
    end
  end

  // ****************************************
  // memory wait states and upper address
  // ****************************************
  cpm_wait_gen u_prog_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (prog_rd_i),
    .extra_i (program_read_wait_r),
    .wait_o  (prog_wait_w)
  );

  cpm_wait_gen u_xram_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (xram_rd_i | (xram_wr_i & xram_write_extend_r)),
    .extra_i (xram_rd_i ? xram_read_wait_r : `CPM_XWR_EXTRA),
    .wait_o  (xrd_wait_w)
  );

  // writes share the xram stretcher: a read and a write never overlap,
  // so one counter serves both directions

  always @(posedge clk_i) begin
    if (rst_i) begin
      prog_wait_o       <= 1'b0;
      xram_wait_o       <= 1'b0;
      xram_upper_addr_o <= 8'h00;
    end else begin
      prog_wait_o <= prog_wait_w;
      xram_wait_o <= xrd_wait_w;
      // port2 latch on an indirect access when select is 0, zero otherwise
      if (xram_indirect_i && !upper_address_select_r)
        xram_upper_addr_o <= port2_output_latch_i;
      else
        xram_upper_addr_o <= 8'h00;
    end
  end
endmodule // cpm_ctrl

/* verification/cpm_ctrl_asserts.sv */
`timescale 1ns/10ps
// ********
// port checker
// ********
module cpm_ctrl_asserts (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [9:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // wake, waits, clocks
  input wire [7:0]  port0_pins_i,
  input wire        prog_wait_o,
  input wire        cpu_clk_en_o,
  input wire        cpu_halt_o,
  input wire        periph_halt_o,
  input wire        osc_stop_o,
  input wire [2:0]  cpu_divider_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // taken apply command
  wire      apw = cyc_i & stb_i & ~ack_o & we_i & sel_i[0] & (adr_i == 10'h398) & (dat_i[7:0] == 8'h69);
  reg [3:0] pw_r;
  // run length of one stretch
  always @(posedge clk_i) pw_r <= (rst_i || !prog_wait_o) ? 4'h0 : pw_r + 4'h1;
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_pc_wr;
    s_take ##0 (we_i && sel_i[0] && adr_i == 10'h21C);
  endsequence
  property p_ack_next;
    s_take |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one pulse");
  property p_cmd_zero;
    s_take ##0 (!we_i && adr_i == 10'h398) |=> dat_o == 32'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command read nonzero");
  property p_div_hold;
    $changed(cpu_divider_code_o) |-> $past(apw) || $past(apw, 2) || $past(apw, 3);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider moved unapplied");
  property p_prog_max;
    prog_wait_o |-> pw_r < 4'h7;
  endproperty
  a_prog_max: assert property (p_prog_max) else $error("program stretch too long");
  property p_halt_clk;
    cpu_halt_o && $past(cpu_halt_o) |-> !cpu_clk_en_o;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("clock while halted");
  property p_stop_all;
    osc_stop_o && $past(osc_stop_o) |-> cpu_halt_o && periph_halt_o;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("stop left units running");
  property p_idle_in;
    s_pc_wr ##0 (dat_i[1:0] == 2'b01) |-> ##[1:3] (cpu_halt_o && !periph_halt_o);
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("idle not entered");
  property p_stop_in;
    s_pc_wr ##0 dat_i[1] |-> ##[1:3] osc_stop_o;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop not entered");
  property p_p0_wake;
    cpu_halt_o && !periph_halt_o && !$stable(port0_pins_i) |-> ##[1:4] !cpu_halt_o;
  endproperty
  a_p0_wake: assert property (p_p0_wake) else $error("no wake from port0");
endmodule // cpm_ctrl_asserts
bind cpm_ctrl cpm_ctrl_asserts cpm_ctrl_asserts_i (.*);

/* verification/cpm_core_model.sv */
`timescale 1ns/10ps
// ********
// core access model
// ********
module cpm_core_model (
  // clock
  input wire clk_i,
  // stretch from block
  input wire prog_wait_i,
  input wire xram_wait_i,
  // access starts
  output reg prog_rd_o,
  output reg xram_rd_o,
  output reg xram_wr_o
);
  integer k;
  initial {prog_rd_o, xram_rd_o, xram_wr_o} = 3'h0;
  // one access, then count stretch cycles over the next 12 clocks
  task access(input integer kind, output integer n);
    begin
      n = 0;
      prog_rd_o <= (kind == 0);
      xram_rd_o <= (kind == 1);
      xram_wr_o <= (kind == 2);
      @(posedge clk_i);
      {prog_rd_o, xram_rd_o, xram_wr_o} <= 3'h0;
      for (k = 0; k < 12; k = k + 1) begin
        @(posedge clk_i);
        if ((kind == 0) ? prog_wait_i : xram_wait_i)
          n = n + 1;
      end
    end
  endtask
endmodule // cpm_core_model

/* verification/tb_cpm_ctrl.sv */
`timescale 1ns/10ps
module tb_cpm_ctrl;
  // ********
  // bench nets
  // ********
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, osc_tick_i, lowosc_tick_i;
  reg         xram_indirect_i, irq_pending_i, global_irq_en_i;
  reg  [9:0]  adr_i;
  reg  [3:0]  sel_i;
  reg  [31:0] dat_i;
  reg  [7:0]  port2_output_latch_i, port0_pins_i, port1_pins_i, q;
  wire [31:0] dat_o;
  wire [7:0]  xram_upper_addr_o;
  wire [2:0]  cpu_divider_code_o;
  wire        ack_o, prog_rd_i, xram_rd_i, xram_wr_i, prog_wait_o, xram_wait_o;
  wire        cpu_clk_en_o, cpu_halt_o, periph_halt_o, osc_stop_o;
  integer     failures, tests_run, i, n, cyc_cnt;
  cpm_ctrl cpm_ctrl_i (.*);
  cpm_core_model cpm_core_model_i (.clk_i(clk_i), .prog_wait_i(prog_wait_o), .xram_wait_i(xram_wait_o),
    .prog_rd_o(prog_rd_i), .xram_rd_o(xram_rd_i), .xram_wr_o(xram_wr_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // classic cycle: hold until ack seen, then one idle cycle
  task wb(input w, input [7:0] ix, input [7:0] d, output [7:0] r);
    integer t;
    begin
      t = 0;
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      adr_i <= {ix, 2'b00};
      dat_i <= {24'h0, d};
      do begin
        @(posedge clk_i);
        t = t + 1;
      end while (ack_o !== 1'b1 && t < 20);
      if (t >= 20) begin
        failures = failures + 1;
        $display("BAD %0t no ack", $time);
      end
      r = dat_o[7:0];
      {cyc_i, stb_i, we_i} <= 3'h0;
      @(posedge clk_i);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rd(input [7:0] ix, input [7:0] e);
    begin
      wb(1'b0, ix, 8'h00, q);
      chk(q, e);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk_i);
  endtask
  // oscillator enables, high or low speed
  task pulse(input integer k, input lo);
    begin
      repeat (k) begin
        osc_tick_i <= !lo;
        lowosc_tick_i <= lo;
        @(posedge clk_i);
      end
      {osc_tick_i, lowosc_tick_i} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d bad %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures = failures + 1;
      $display("BAD %0t timeout", $time);
      summarize;
    end
  end
  initial begin
    {cyc_i, stb_i, we_i, osc_tick_i, lowosc_tick_i, xram_indirect_i, irq_pending_i, global_irq_en_i} = 8'h00;
    {adr_i, sel_i, dat_i} = {10'h000, 4'h1, 32'h0};
    {port2_output_latch_i, port0_pins_i, port1_pins_i} = {8'hA5, 8'h00, 8'h00};
    {failures, tests_run, cyc_cnt} = 0;
    rst_i = 1'b1;
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    rd(8'h87, 8'h08);
    rd(8'h8E, 8'h71);
    rd(8'h91, 8'h00);
    rd(8'hE5, 8'h07);
    rd(8'hE6, 8'h00);
    rd(8'h10, 8'h00);
    $display("reset values done");
    // every wait code, write extension off then on
    for (i = 0; i < 16; i = i + 1) begin
      wb(1'b1, 8'h8E, {1'b0, i[2:0], i[3], i[2:0]}, q);
      cpm_core_model_i.access(0, n);
      chk(n, i % 8);
      cpm_core_model_i.access(1, n);
      chk(n, i % 8);
      cpm_core_model_i.access(2, n);
      chk(n, i / 8);
    end
    $display("waits done");
    xram_indirect_i <= 1'b1;
    wb(1'b1, 8'h87, 8'h04, q);
    rd(8'h87, 8'h04);
    cpm_core_model_i.access(1, n);
    chk(xram_upper_addr_o, 8'hA5);
    wb(1'b1, 8'h87, 8'h08, q);
    cpm_core_model_i.access(1, n);
    chk(xram_upper_addr_o, 8'h00);
    // selection without the apply code stays pending
    wb(1'b1, 8'hE5, 8'h00, q);
    wb(1'b1, 8'hE6, 8'h12, q);
    tick(3);
    chk(cpu_divider_code_o, 3'h7);
    for (i = 0; i < 8; i = i + 1) begin
      wb(1'b1, 8'hE5, i[7:0], q);
      wb(1'b1, 8'hE6, 8'h69, q);
      tick(130);
      chk(cpu_divider_code_o, i);
      n = 0;
      repeat (256) begin
        @(posedge clk_i);
        if (cpu_clk_en_o === 1'b1)
          n = n + 1;
      end
      chk(n, 2 << i);
    end
    $display("divider done");
    wb(1'b1, 8'h91, 8'h01, q);
    wb(1'b1, 8'h87, 8'h09, q);
    tick(4);
    chk({cpu_halt_o, periph_halt_o}, 2'b10);
    port1_pins_i <= 8'h02;
    tick(4);
    chk(cpu_halt_o, 1'b1);
    port1_pins_i <= 8'h03;
    tick(4);
    chk(cpu_halt_o, 1'b0);
    rd(8'h87, 8'h08);
    // port 0 wakes idle with no enable bit
    wb(1'b1, 8'h87, 8'h09, q);
    port0_pins_i <= 8'h01;
    tick(4);
    chk(cpu_halt_o, 1'b0);
    wb(1'b1, 8'h87, 8'h09, q);
    irq_pending_i <= 1'b1;
    tick(4);
    chk(cpu_halt_o, 1'b1);
    global_irq_en_i <= 1'b1;
    tick(4);
    chk(cpu_halt_o, 1'b0);
    $display("idle done");
    // stop ignores interrupts; rc count by port 0, crystal count by port 1
    for (i = 0; i < 2; i = i + 1) begin
      wb(1'b1, 8'hF0, {7'h0, ~i[0]}, q);
      wb(1'b1, 8'h87, 8'h0A, q);
      tick(4);
      chk({osc_stop_o, periph_halt_o, cpu_halt_o}, 3'h7);
      {irq_pending_i, global_irq_en_i} <= 2'b00;
      if (i == 0)
        port0_pins_i <= 8'h80;
      else
        port1_pins_i <= 8'h02;
      tick(3);
      pulse((i == 0) ? 63 : 2047, 1'b0);
      pulse(5, 1'b1);
      chk(cpu_halt_o, 1'b1);
      pulse(1, 1'b0);
      pulse(5, 1'b1);
      tick(3);
      chk(cpu_halt_o, 1'b0);
      rd(8'h87, 8'h08);
    end
    $display("stop done");
    summarize;
  end
endmodule // tb_cpm_ctrl
